// >>> hw/tmrc_core.sv
// task management response codec: wishbone registers, send sequencer, dispatch
//
// Functional notes
// - response message carries message code 83h and protocol code 03h.
// - tag byte of every built response is zero.
// - rejected to invalid parameter, complete to successful, failure to failed.
// - transmit request always carries control value zero.
// - transmit destination equals the executed function's destination.
// - transmit points at the response buffer and gives its byte length.
// - valid task management message raises upward indication with address and function.
// - transfer offset is four bytes, relative to buffer base.
// - transfer count is four bytes, bytes of this one request only.
// - message length argument is one byte counting data field bytes.
// - channel argument is two bytes, used in read data frame address.
// - with substitution flag, transport overwrites bytes 4 to 7 with path id.
// - transport stores the body, then signals control, location and length.
// - validated messages are dispatched by their type code.
// - return path field is filled from the path identifier for that path.
`timescale 1ns/10ps
module tmrc_core (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // wishbone classic slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [4:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // executed function from the device server
   input  wire logic                  tmf_done_i,
   input  wire tmrc_pkg::tmrc_srsp_t  tmf_srsp_i,
   input  wire logic [31:0]           tmf_dest_i,
   output logic                       tmf_ready_o,
   // transmit request to the transport
   output logic                       send_req_o,
   output logic      [7:0]            send_ctrl_o,
   output logic      [31:0]           send_dest_o,
   output logic      [7:0]            send_buf_o,
   output logic      [7:0]            send_len_o,
   output logic                       path_id_substitute_flag_o,
   input  wire logic                  send_ack_i,
   input  wire logic [7:0]            send_rc_i,
   input  wire logic [2:0]            sms_rd_addr_i,
   output logic      [7:0]            sms_rd_data_o,
   // receive side from the transport
   input  wire logic                  rx_wr_en_i,
   input  wire logic [4:0]            rx_wr_addr_i,
   input  wire logic [7:0]            rx_wr_data_i,
   input  wire logic                  sms_rcv_i,
   input  wire logic [7:0]            sms_rcv_ctrl_i,
   input  wire logic [4:0]            sms_rcv_buf_i,
   input  wire logic [7:0]            sms_rcv_len_i,
   // upward indications
   output logic                       tm_req_rcvd_o,
   output logic      [31:0]           tm_obj_addr_o,
   output logic      [7:0]            tm_fn_id_o,
   output logic                       cmd_rcvd_o,
   output logic                       status_rcvd_o,
   output logic                       fn_exec_o,
   output tmrc_pkg::tmrc_srsp_t       fn_srsp_o,
   // data transfer arguments
   output logic      [31:0]           xfer_offset_o,
   output logic      [31:0]           xfer_count_o,
   output logic      [15:0]           xfer_chan_o,
   output logic                       xfer_in_order_o
);

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_BUILD = 2'b01,
      ST_SEND  = 2'b10
   } tmrc_state_t;

   tmrc_state_t          state_r;
   tmrc_state_t          state_nxt;
   tmrc_pkg::tmrc_srsp_t srsp_r;
   logic [31:0]          dest_r;
   logic [2:0]           ctrl_r;
   logic [31:0]          rpid_r;
   logic [31:0]          offs_r;
   logic [31:0]          cnt_r;
   logic [15:0]          chan_r;
   logic [7:0]           last_rc_r;
   logic [7:0]           rx_ctrl_r;
   logic [7:0]           rx_len_r;
   logic [15:0]          drop_cnt_r;
   logic                 ack_r;
   logic [31:0]          rd_data_r;
   logic                 rx_drop_w;

   // merge write data into a register under the byte lane selects
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      for (int b = 0; b < 4; b++) begin
         lane_merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
      end
   endfunction : lane_merge

   // bus decode
   wire logic req_w      = wb_cyc_i && wb_stb_i && !ack_r;
   // write lands at the edge that samples ack, while the master still holds it
   wire logic wr_w       = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
   wire logic hit_ctrl   = wb_adr_i == tmrc_pkg::REG_CTRL;
   wire logic hit_stat   = wb_adr_i == tmrc_pkg::REG_STAT;
   wire logic hit_rpid   = wb_adr_i == tmrc_pkg::REG_RPID;
   wire logic hit_offs   = wb_adr_i == tmrc_pkg::REG_OFFS;
   wire logic hit_cnt    = wb_adr_i == tmrc_pkg::REG_CNT;
   wire logic hit_chan   = wb_adr_i == tmrc_pkg::REG_CHAN;
   wire logic hit_rxinfo = wb_adr_i == tmrc_pkg::REG_RXINFO;
   wire logic hit_drop   = wb_adr_i == tmrc_pkg::REG_DROP;
   // channel merged as a word, only the low two lanes are kept
   wire logic [31:0] chan_mrg_w = lane_merge({16'h0, chan_r}, wb_dat_i, wb_sel_i);

   // status word shows the sequencer state and last transport answer
   wire logic [31:0] stat_w = (32'(state_r != ST_IDLE) << tmrc_pkg::STAT_BSY_BIT) |
                              (32'(state_r == ST_SEND) << tmrc_pkg::STAT_PND_BIT) |
                              (32'(last_rc_r) << tmrc_pkg::STAT_RC_LSB);
   wire logic [31:0] rxinfo_w = {8'h00, tm_fn_id_o, rx_ctrl_r, rx_len_r};

   // read selection; unmapped addresses read as zero but still ack
   wire logic [31:0] rd_mux_w =
      hit_ctrl   ? {29'h0, ctrl_r} :
      hit_stat   ? stat_w :
      hit_rpid   ? rpid_r :
      hit_offs   ? offs_r :
      hit_cnt    ? cnt_r :
      hit_chan   ? {16'h0, chan_r} :
      hit_rxinfo ? rxinfo_w :
      hit_drop   ? {16'h0, drop_cnt_r} : 32'h0000_0000;

   // single-wait ack; dropped the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r     <= 1'b0;
         rd_data_r <= tmrc_pkg::WORD_RST;
      end else begin
         ack_r     <= req_w;
         rd_data_r <= req_w ? rd_mux_w : rd_data_r;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_data_r;

   // software control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= tmrc_pkg::CTRL_RST;
         rpid_r <= tmrc_pkg::WORD_RST;
         offs_r <= tmrc_pkg::WORD_RST;
         cnt_r  <= tmrc_pkg::WORD_RST;
         chan_r <= 16'h0000;
      end else if (wr_w) begin
         if (hit_ctrl) ctrl_r <= wb_sel_i[0] ? wb_dat_i[2:0] : ctrl_r;
         if (hit_rpid) rpid_r <= lane_merge(rpid_r, wb_dat_i, wb_sel_i);
         if (hit_offs) offs_r <= lane_merge(offs_r, wb_dat_i, wb_sel_i);
         if (hit_cnt)  cnt_r  <= lane_merge(cnt_r, wb_dat_i, wb_sel_i);
         if (hit_chan) chan_r <= chan_mrg_w[15:0];
      end
   end

   // transfer arguments straight from registers
   assign xfer_offset_o   = offs_r;
   assign xfer_count_o    = cnt_r;
   assign xfer_chan_o     = chan_r;
   assign xfer_in_order_o = ctrl_r[tmrc_pkg::CTRL_ORD_BIT];

   // drop counter: a drop in the clearing cycle still counts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drop_cnt_r <= 16'h0000;
      end else if (rx_drop_w) begin
         drop_cnt_r <= (wr_w && hit_drop) ? 16'h0001 : drop_cnt_r + 16'h0001;
      end else if (wr_w && hit_drop) begin
         drop_cnt_r <= 16'h0000;
      end
   end

   // capture control and length of every receipt for software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_ctrl_r <= 8'h00;
         rx_len_r  <= 8'h00;
      end else if (sms_rcv_i) begin
         rx_ctrl_r <= sms_rcv_ctrl_i;
         rx_len_r  <= sms_rcv_len_i;
      end
   end

   // send sequencer: one response in flight, the device server waits on ready
   assign tmf_ready_o = (state_r == ST_IDLE) && ctrl_r[tmrc_pkg::CTRL_EN_BIT];
   wire logic accept_w = tmf_done_i && tmf_ready_o;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (accept_w) state_nxt = ST_BUILD;
         ST_BUILD: state_nxt = ST_SEND;
         ST_SEND:  if (send_ack_i) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) state_r <= ST_IDLE;
      else       state_r <= state_nxt;
   end

   // latch the executed function's arguments at acceptance
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         srsp_r <= tmrc_pkg::SR_COMPLETE;
         dest_r <= tmrc_pkg::WORD_RST;
      end else if (accept_w) begin
         srsp_r <= tmf_srsp_i;
         dest_r <= tmf_dest_i;
      end
   end

   // return code of the transport kept for status reads
   always_ff @(posedge clk_i) begin
      if (rst_i)                                last_rc_r <= tmrc_pkg::RC_SUCCESS;
      else if (state_r == ST_SEND && send_ack_i) last_rc_r <= send_rc_i;
   end

   // transmit request held until the transport acks it
   assign send_req_o                = state_r == ST_SEND;
   assign send_ctrl_o               = tmrc_pkg::CTRL_ZERO;
   assign send_dest_o               = dest_r;
   assign send_buf_o                = tmrc_pkg::RSP_BUF_BASE;
   assign send_len_o                = tmrc_pkg::RSP_LEN;
   assign path_id_substitute_flag_o = ctrl_r[tmrc_pkg::CTRL_SUB_BIT];

   tmrc_rsp_builder u_build (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .build_i   (state_r == ST_BUILD),
      .srsp_i    (srsp_r),
      .rpid_i    (rpid_r),
      .rd_addr_i (sms_rd_addr_i),
      .rd_data_o (sms_rd_data_o)
   );

   tmrc_rx_dispatch u_rx (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .wr_en_i    (rx_wr_en_i),
      .wr_addr_i  (rx_wr_addr_i),
      .wr_data_i  (rx_wr_data_i),
      .rcv_i      (sms_rcv_i),
      .rcv_base_i (sms_rcv_buf_i),
      .rcv_len_i  (sms_rcv_len_i),
      .tm_req_o   (tm_req_rcvd_o),
      .cmd_o      (cmd_rcvd_o),
      .status_o   (status_rcvd_o),
      .fn_exec_o  (fn_exec_o),
      .drop_o     (rx_drop_w),
      .obj_addr_o (tm_obj_addr_o),
      .fn_id_o    (tm_fn_id_o),
      .srsp_o     (fn_srsp_o)
   );

   // checks on the built structure, the send request and dispatch
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // structure reads count only once the send state has stood a full cycle
   logic was_send_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) was_send_r <= 1'b0;
      else       was_send_r <= state_r == ST_SEND;
   end
   wire logic rd_ok_w = (state_r == ST_SEND) && was_send_r;

   property p_rsp_code;
      (rd_ok_w && $past(sms_rd_addr_i) == 3'h0) |-> sms_rd_data_o == tmrc_pkg::MSG_CODE;
   endproperty
   a_rsp_code: assert property (p_rsp_code) else $error("bad message code");

   property p_rsp_proto;
      (rd_ok_w && $past(sms_rd_addr_i) == 3'h1) |-> sms_rd_data_o == tmrc_pkg::PROTO_RSP;
   endproperty
   a_rsp_proto: assert property (p_rsp_proto) else $error("bad protocol code");

   property p_rsp_tag;
      (rd_ok_w && $past(sms_rd_addr_i) == 3'h2) |-> sms_rd_data_o == tmrc_pkg::TAG_ZERO;
   endproperty
   a_rsp_tag: assert property (p_rsp_tag) else $error("tag not zero");

   property p_rsp_rc;
      (rd_ok_w && $past(sms_rd_addr_i) == 3'h3) |->
         sms_rd_data_o == tmrc_pkg::rc_encode(srsp_r);
   endproperty
   a_rsp_rc: assert property (p_rsp_rc) else $error("return code mismatch");

   property p_ctrl_zero;
      send_req_o |-> send_ctrl_o == tmrc_pkg::CTRL_ZERO;
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("control not zero");

   property p_dest;
      accept_w |-> ##2 (send_req_o && send_dest_o == $past(tmf_dest_i, 2));
   endproperty
   a_dest: assert property (p_dest) else $error("destination not carried");

   property p_hold;
      (send_req_o && !send_ack_i) |=>
         (send_req_o && $stable(send_dest_o) && send_len_o == tmrc_pkg::RSP_LEN);
   endproperty
   a_hold: assert property (p_hold) else $error("send request not held");

   property p_dispatch;
      sms_rcv_i |=> $onehot({tm_req_rcvd_o, cmd_rcvd_o, status_rcvd_o, fn_exec_o, rx_drop_w});
   endproperty
   a_dispatch: assert property (p_dispatch) else $error("not one outcome");

   property p_quiet;
      !sms_rcv_i |=> !(tm_req_rcvd_o || cmd_rcvd_o || status_rcvd_o || fn_exec_o);
   endproperty
   a_quiet: assert property (p_quiet) else $error("indication without receipt");

   property p_short_drop;
      (sms_rcv_i && sms_rcv_len_i < tmrc_pkg::RX_MIN_LEN) |=> rx_drop_w && !tm_req_rcvd_o;
   endproperty
   a_short_drop: assert property (p_short_drop) else $error("short message kept");

   property p_tm_id;
      tm_req_rcvd_o |-> (tm_fn_id_o >= tmrc_pkg::PROTO_ABT && tm_fn_id_o <= tmrc_pkg::PROTO_CLRACA);
   endproperty
   a_tm_id: assert property (p_tm_id) else $error("bad function id");

   c_send_done: cover property (send_req_o && send_ack_i);
   c_tm_req:    cover property (tm_req_rcvd_o);
   c_fn_exec:   cover property (fn_exec_o);
   c_drop:      cover property (rx_drop_w);

endmodule : tmrc_core

// >>> hw/tmrc_rsp_builder.sv
// response message builder with byte read port for the transport
`timescale 1ns/10ps
module tmrc_rsp_builder (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  build_i,
   input  wire tmrc_pkg::tmrc_srsp_t  srsp_i,
   input  wire logic [31:0]           rpid_i,
   input  wire logic [2:0]            rd_addr_i,
   output logic      [7:0]            rd_data_o
);
   logic [7:0] mem_r [tmrc_pkg::RSP_BYTES];
   logic [7:0] rd_data_r;

   // whole structure is rewritten in one edge, so a read never sees a mix
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < tmrc_pkg::RSP_BYTES; i++) mem_r[i] <= 8'h00;
      end else if (build_i) begin
         mem_r[0] <= tmrc_pkg::MSG_CODE;
         mem_r[1] <= tmrc_pkg::PROTO_RSP;
         mem_r[2] <= tmrc_pkg::TAG_ZERO;
         mem_r[3] <= tmrc_pkg::rc_encode(srsp_i);
         mem_r[4] <= rpid_i[31:24];
         mem_r[5] <= rpid_i[23:16];
         mem_r[6] <= rpid_i[15:8];
         mem_r[7] <= rpid_i[7:0];
      end
   end

   // registered read, one cycle latency
   always_ff @(posedge clk_i) begin
      if (rst_i) rd_data_r <= 8'h00;
      else       rd_data_r <= mem_r[rd_addr_i];
   end

   assign rd_data_o = rd_data_r;
endmodule : tmrc_rsp_builder

// >>> hw/tmrc_rx_dispatch.sv
// receive buffer, message validation and dispatch by type
`timescale 1ns/10ps
module tmrc_rx_dispatch (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wr_en_i,
   input  wire logic [4:0]            wr_addr_i,
   input  wire logic [7:0]            wr_data_i,
   input  wire logic                  rcv_i,
   input  wire logic [4:0]            rcv_base_i,
   input  wire logic [7:0]            rcv_len_i,
   output logic                       tm_req_o,
   output logic                       cmd_o,
   output logic                       status_o,
   output logic                       fn_exec_o,
   output logic                       drop_o,
   output logic      [31:0]           obj_addr_o,
   output logic      [7:0]            fn_id_o,
   output tmrc_pkg::tmrc_srsp_t       srsp_o
);
   localparam int RX_DEPTH_L = tmrc_pkg::RX_DEPTH;
   logic [7:0] buf_r [RX_DEPTH_L];

   // byte k of the message, wrapping inside the buffer
   function automatic logic [7:0] msg_byte(input logic [2:0] k);
      msg_byte = buf_r[rcv_base_i + {2'b00, k}];
   endfunction : msg_byte

   // transport stores the body before it signals receipt
   always_ff @(posedge clk_i) begin
      if (wr_en_i) buf_r[wr_addr_i] <= wr_data_i;
   end

   wire logic [7:0] code_w  = msg_byte(3'h1);
   wire logic       len_ok  = (rcv_len_i >= tmrc_pkg::RX_MIN_LEN) &&
                              (rcv_len_i <= tmrc_pkg::RX_MAX_LEN);
   wire logic       valid_w = rcv_i && len_ok && (msg_byte(3'h0) == tmrc_pkg::MSG_CODE);
   wire logic       is_tm   = (code_w == tmrc_pkg::PROTO_ABT) ||
                              (code_w == tmrc_pkg::PROTO_ABTSET) ||
                              (code_w == tmrc_pkg::PROTO_CLRQ) ||
                              (code_w == tmrc_pkg::PROTO_TRST) ||
                              (code_w == tmrc_pkg::PROTO_CLRACA);
   wire logic       is_cmd  = code_w == tmrc_pkg::PROTO_CMD;
   wire logic       is_stat = code_w == tmrc_pkg::PROTO_STAT;
   wire logic       is_rsp  = code_w == tmrc_pkg::PROTO_RSP;
   wire logic       known_w = is_tm || is_cmd || is_stat || is_rsp;

   // one pulse per received message: a handler, or dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tm_req_o   <= 1'b0;
         cmd_o      <= 1'b0;
         status_o   <= 1'b0;
         fn_exec_o  <= 1'b0;
         drop_o     <= 1'b0;
         obj_addr_o <= 32'h0000_0000;
         fn_id_o    <= 8'h00;
         srsp_o     <= tmrc_pkg::SR_COMPLETE;
      end else begin
         tm_req_o  <= valid_w && is_tm;
         cmd_o     <= valid_w && is_cmd;
         status_o  <= valid_w && is_stat;
         fn_exec_o <= valid_w && is_rsp;
         drop_o    <= rcv_i && !(valid_w && known_w);
         if (valid_w && known_w) begin
            obj_addr_o <= {msg_byte(3'h4), msg_byte(3'h5), msg_byte(3'h6), msg_byte(3'h7)};
            fn_id_o    <= code_w;
            srsp_o     <= tmrc_pkg::rc_decode(msg_byte(3'h3));
         end
      end
   end
endmodule : tmrc_rx_dispatch

// >>> include/tmrc_pkg.sv
// package: constants, types and return-code codecs of the task management codec
package tmrc_pkg;
   // message header bytes
   localparam logic [7:0] MSG_CODE     = 8'h83;
   localparam logic [7:0] PROTO_RSP    = 8'h03;
   localparam logic [7:0] TAG_ZERO     = 8'h00;
   localparam logic [7:0] CTRL_ZERO    = 8'h00;
   localparam logic [7:0] PROTO_CMD    = 8'h01;
   localparam logic [7:0] PROTO_STAT   = 8'h02;
   localparam logic [7:0] PROTO_ABT    = 8'h30;
   localparam logic [7:0] PROTO_ABTSET = 8'h31;
   localparam logic [7:0] PROTO_CLRQ   = 8'h32;
   localparam logic [7:0] PROTO_TRST   = 8'h33;
   localparam logic [7:0] PROTO_CLRACA = 8'h34;
   // return codes on the transport side
   localparam logic [7:0] RC_SUCCESS   = 8'h00;
   localparam logic [7:0] RC_FAILED    = 8'h01;
   localparam logic [7:0] RC_INVALID   = 8'h02;
   // response structure and receive buffer
   localparam int         RSP_BYTES    = 8;
   localparam logic [7:0] RSP_LEN      = 8'h08;
   localparam logic [7:0] RSP_BUF_BASE = 8'h00;
   localparam int         RX_DEPTH     = 32;
   localparam logic [7:0] RX_MAX_LEN   = 8'h20;
   localparam logic [7:0] RX_MIN_LEN   = 8'h08;
   // register byte offsets
   localparam logic [4:0] REG_CTRL     = 5'h00;
   localparam logic [4:0] REG_STAT     = 5'h04;
   localparam logic [4:0] REG_RPID     = 5'h08;
   localparam logic [4:0] REG_OFFS     = 5'h0c;
   localparam logic [4:0] REG_CNT      = 5'h10;
   localparam logic [4:0] REG_CHAN     = 5'h14;
   localparam logic [4:0] REG_RXINFO   = 5'h18;
   localparam logic [4:0] REG_DROP     = 5'h1c;
   // field positions and reset values
   localparam int         CTRL_EN_BIT  = 0;
   localparam int         CTRL_SUB_BIT = 1;
   localparam int         CTRL_ORD_BIT = 2;
   localparam int         STAT_BSY_BIT = 0;
   localparam int         STAT_PND_BIT = 1;
   localparam int         STAT_RC_LSB  = 8;
   localparam logic [2:0] CTRL_RST     = 3'h1;
   localparam logic [31:0] WORD_RST    = 32'h0000_0000;

   typedef enum logic [1:0] {
      SR_COMPLETE = 2'b00,
      SR_REJECTED = 2'b01,
      SR_FAILURE  = 2'b10
   } tmrc_srsp_t;

   // service response to return code
   function automatic logic [7:0] rc_encode(input tmrc_srsp_t sr);
      unique case (sr)
         SR_REJECTED: rc_encode = RC_INVALID;
         SR_COMPLETE: rc_encode = RC_SUCCESS;
         default:     rc_encode = RC_FAILED;
      endcase
   endfunction : rc_encode

   // inverse mapping; unknown codes read as failure
   function automatic tmrc_srsp_t rc_decode(input logic [7:0] rc);
      rc_decode = (rc == RC_SUCCESS) ? SR_COMPLETE :
                  (rc == RC_INVALID) ? SR_REJECTED : SR_FAILURE;
   endfunction : rc_decode
endpackage : tmrc_pkg

// >>> tb/task_mgmt_response_codec_test.sv
// self-checking bench of the task management codec
`timescale 1ns/10ps
module task_mgmt_response_codec_test;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tmf_done_i, tmf_ready_o;
   logic send_req_o, send_ack_i, path_id_substitute_flag_o, rx_wr_en_i, sms_rcv_i;
   logic tm_req_rcvd_o, cmd_rcvd_o, status_rcvd_o, fn_exec_o, xfer_in_order_o;
   logic [31:0] wb_dat_i, wb_dat_o, tmf_dest_i, send_dest_o, tm_obj_addr_o;
   logic [31:0] xfer_offset_o, xfer_count_o, q, rp;
   logic [7:0] send_ctrl_o, send_buf_o, send_len_o, send_rc_i, sms_rd_data_o, rx_wr_data_i;
   logic [7:0] sms_rcv_ctrl_i, sms_rcv_len_i, tm_fn_id_o, rcx, e;
   logic [4:0] wb_adr_i, rx_wr_addr_i, sms_rcv_buf_i, stall, b;
   logic [3:0] wb_sel_i;
   logic [2:0] sms_rd_addr_i;
   logic [15:0] xfer_chan_o;
   tmrc_pkg::tmrc_srsp_t tmf_srsp_i, fn_srsp_o;
   logic [7:0] m[8];
   logic [7:0] codes[13] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h01, 8'h02, 8'h03,
                             8'h03, 8'h03, 8'h55, 8'h03, 8'h30};
   int mismatches = 0, checks = 0, seed = 22, i, k, ev;

   tmrc_core i_dut (.*);
   tmrc_xport_model i_xport (.clk_i, .send_req_i(send_req_o), .rc_i(rcx), .stall_i(stall),
                             .send_ack_o(send_ack_i), .send_rc_o(send_rc_i));

   // clock and hang guard
   initial begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      give_verdict();
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         mismatches++;
         $display("FAIL %s exp %h got %h", n, x, g);
      end
   endtask : chk

   // classic cycle; waits for ack, then one idle cycle
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
      do tick(1); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 0; wb_stb_i <= 0;
      tick(1);
   endtask : wb

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // main sequence: registers, response sends, receive dispatch
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, tmf_done_i, rx_wr_en_i, sms_rcv_i, wb_adr_i} = '0;
      {wb_dat_i, tmf_dest_i, sms_rd_addr_i, rx_wr_addr_i, rx_wr_data_i, rcx, stall} = '0;
      {sms_rcv_ctrl_i, sms_rcv_buf_i, sms_rcv_len_i} = '0;
      wb_sel_i = 4'hf;
      tmf_srsp_i = tmrc_pkg::SR_COMPLETE;
      rst_i = 1;
      tick(6);
      rst_i <= 0;
      tick(1);
      wb(0, tmrc_pkg::REG_CTRL, 0); chk("ctrl", 1, q);
      rp = $random(seed);
      wb(1, tmrc_pkg::REG_RPID, rp);
      wb(1, tmrc_pkg::REG_CTRL, 6);
      chk("ready", 0, tmf_ready_o);
      tmf_done_i <= 1;
      tick(3);
      tmf_done_i <= 0;
      chk("nosend", 0, send_req_o);
      wb(1, tmrc_pkg::REG_CTRL, 7);
      wb(1, tmrc_pkg::REG_OFFS, rp + 1); chk("offs", rp + 1, xfer_offset_o);
      wb(1, tmrc_pkg::REG_CNT, ~rp); chk("cnt", ~rp, xfer_count_o);
      wb(1, tmrc_pkg::REG_CHAN, rp); chk("chan", rp[15:0], xfer_chan_o);
      chk("order", 1, xfer_in_order_o);
      chk("subst", 1, path_id_substitute_flag_o);
      wb(0, 5'h02, 0); chk("unmapped", 0, q);
      $display("registers done");
      for (i = 0; i < 3; i++) begin
         rcx = $random(seed);
         stall = 5'd17 + i[4:0];
         e = (i == 1) ? 8'h02 : (i == 0) ? 8'h00 : 8'h01;
         m = '{8'h83, 8'h03, 8'h00, e, rp[31:24], rp[23:16], rp[15:8], rp[7:0]};
         chk("ready", 1, tmf_ready_o);
         tmf_dest_i <= $random(seed); tmf_srsp_i <= tmrc_pkg::tmrc_srsp_t'(i); tmf_done_i <= 1;
         tick(1);
         tmf_done_i <= 0;
         for (k = 0; k < 50 && send_req_o !== 1'b1; k++) tick(1);
         chk("busy", 0, tmf_ready_o);
         chk("sctrl", 0, send_ctrl_o);
         chk("dest", tmf_dest_i, send_dest_o);
         chk("sbuf", tmrc_pkg::RSP_BUF_BASE, send_buf_o);
         chk("slen", 8, send_len_o);
         for (k = 0; k < 8; k++) begin
            sms_rd_addr_i <= k[2:0];
            tick(2);
            chk("sms", m[k], sms_rd_data_o);
         end
         for (k = 0; k < 50 && send_req_o !== 1'b0; k++) tick(1);
         wb(0, tmrc_pkg::REG_STAT, 0); chk("strc", rcx, q[15:8]);
      end
      $display("sends done");
      for (i = 0; i < 13; i++) begin
         for (k = 0; k < 8; k++) m[k] = $random(seed);
         m[0] = (i == 11) ? 8'h82 : 8'h83;
         m[1] = codes[i];
         if (i >= 7 && i <= 9) m[3] = i - 7;
         b = $random(seed);
         for (k = 0; k < 8; k++) begin
            rx_wr_en_i <= 1; rx_wr_addr_i <= b + k[4:0]; rx_wr_data_i <= m[k];
            tick(1);
         end
         rx_wr_en_i <= 0; sms_rcv_i <= 1; sms_rcv_buf_i <= b; sms_rcv_ctrl_i <= $random(seed);
         sms_rcv_len_i <= (i == 12) ? 8'h07 : 8'h08 + 8'({$random(seed)} % 25);
         tick(1);
         sms_rcv_i <= 0;
         tick(1);
         ev = (m[0] != 8'h83 || i == 12) ? 0 : (m[1] inside {[8'h30:8'h34]}) ? 8 :
              (m[1] == 1) ? 4 : (m[1] == 2) ? 2 : (m[1] == 3) ? 1 : 0;
         chk("pulse", ev, {tm_req_rcvd_o, cmd_rcvd_o, status_rcvd_o, fn_exec_o});
         if (ev == 8) chk("obj", {m[4], m[5], m[6], m[7]}, tm_obj_addr_o);
         if (ev == 8) chk("fnid", m[1], tm_fn_id_o);
         if (ev == 1) chk("srsp", (m[3] == 0) ? 0 : (m[3] == 2) ? 1 : 2, fn_srsp_o);
      end
      wb(0, tmrc_pkg::REG_DROP, 0); chk("drop", 3, q);
      $display("receive done");
      give_verdict();
   end
endmodule : task_mgmt_response_codec_test

// >>> tb/tmrc_xport_model.sv
// transport model: accepts send requests after a set stall
`timescale 1ns/10ps
module tmrc_xport_model (
   input  wire logic       clk_i,
   input  wire logic       send_req_i,
   input  wire logic [7:0] rc_i,
   input  wire logic [4:0] stall_i,
   output logic            send_ack_o,
   output logic [7:0]      send_rc_o
);
   logic [4:0] wait_r;
   initial {send_ack_o, send_rc_o, wait_r} = '0;
   // rc toggles outside the ack cycle so a stale value is never mistaken
   always @(posedge clk_i) begin
      send_ack_o <= 1'b0;
      send_rc_o  <= ~send_rc_o;
      if (!send_req_i || send_ack_o) wait_r <= 5'h00;
      else if (wait_r == stall_i) begin
         send_ack_o <= 1'b1;
         send_rc_o  <= rc_i;
      end else wait_r <= wait_r + 5'h01;
   end
endmodule : tmrc_xport_model
